// file: mdl_decoder.sv
// Multiply, divide, adjust, extend, shift and logic instruction decoder.
`timescale 1ns/1ps
module mdl_decoder (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Instruction byte stream
	input wire logic [7:0] instr_byte_in,
	input wire logic byte_valid_in,
	output logic byte_ready_out,
	// Execution context
	input wire logic bus8_in,
	input wire logic [7:0] var_count_in,
	// Decode results
	output mdl_pkg::mdl_op_t op_class_out,
	output logic [2:0] shift_operation_field_out,
	output logic word_out,
	output logic mem_out,
	output logic writes_result_out,
	output logic [8:0] clocks_out,
	output logic busy_out,
	output logic done_out,
	output logic illegal_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum {S_OPC, S_MODRM, S_SECOND, S_TAIL, S_LOAD, S_EXEC} mdl_state_t;

	mdl_state_t state_reg, state_next;
	mdl_pkg::mdl_op_t op_reg, op_next;
	logic [2:0] field_reg, field_next;
	logic word_reg, word_next;
	logic mem_reg, mem_next;
	logic [2:0] imm_reg, imm_next;
	logic [2:0] tail_reg, tail_next;
	logic [7:0] last_byte_reg, last_byte_next;
	logic [8:0] cnt_reg, cnt_next;
	logic [8:0] clocks_reg, clocks_next;
	logic done_reg, done_next;
	logic illegal_reg, illegal_next;
	logic take;

	mdl_time_if tif ();

	mdl_clock_table u_table (
		.t(tif.table_end)
	);

	// Counted shift forms use the immediate count byte or the count register.
	assign tif.op = op_reg;
	assign tif.word = word_reg;
	assign tif.mem = mem_reg;
	assign tif.bus8 = bus8_in;
	assign tif.var_n = (op_reg == mdl_pkg::OP_SHIMM) ? last_byte_reg : var_count_in;

	assign take = byte_valid_in && byte_ready_out;

	// Displacement bytes that follow the modifier byte.
	function automatic logic [2:0] disp_bytes(input logic [7:0] modrm);
		if (modrm[7:6] == mdl_pkg::MOD_DISP8) begin
			disp_bytes = 3'h1;
		end else if (modrm[7:6] == mdl_pkg::MOD_DISP16) begin
			disp_bytes = 3'h2;
		end else if (modrm[7:6] == mdl_pkg::MOD_NODISP && modrm[2:0] == mdl_pkg::RM_DIRECT) begin
			disp_bytes = 3'h2;
		end else begin
			disp_bytes = 3'h0;
		end
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// One byte is accepted per cycle while fetching; execution stalls the stream.
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		field_next = field_reg;
		word_next = word_reg;
		mem_next = mem_reg;
		imm_next = imm_reg;
		tail_next = tail_reg;
		last_byte_next = last_byte_reg;
		cnt_next = cnt_reg;
		clocks_next = clocks_reg;
		done_next = 1'b0;
		illegal_next = 1'b0;
		case (state_reg)
			S_OPC: begin
				if (take) begin
					word_next = instr_byte_in[0];
					mem_next = 1'b0;
					imm_next = 3'h0;
					state_next = S_MODRM;
					if (instr_byte_in[7:1] == mdl_pkg::OPC_GRP3) begin
						op_next = mdl_pkg::OP_GRP3;
					end else if (instr_byte_in[7:2] == mdl_pkg::OPC_SMUL_IMM && instr_byte_in[0]) begin
						op_next = mdl_pkg::OP_SMUL_IMM;
						word_next = 1'b1;
						imm_next = instr_byte_in[1] ? 3'h1 : 3'h2;
					end else if (instr_byte_in == mdl_pkg::OPC_AAM) begin
						op_next = mdl_pkg::OP_AAM;
						state_next = S_SECOND;
					end else if (instr_byte_in == mdl_pkg::OPC_AAD) begin
						op_next = mdl_pkg::OP_AAD;
						state_next = S_SECOND;
					end else if (instr_byte_in == mdl_pkg::OPC_CBW) begin
						op_next = mdl_pkg::OP_CBW;
						state_next = S_LOAD;
					end else if (instr_byte_in == mdl_pkg::OPC_CWD) begin
						op_next = mdl_pkg::OP_CWD;
						state_next = S_LOAD;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_SH1) begin
						op_next = mdl_pkg::OP_SH1;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_SHCL) begin
						op_next = mdl_pkg::OP_SHCL;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_SHIMM) begin
						op_next = mdl_pkg::OP_SHIMM;
						imm_next = 3'h1;
					end else if (instr_byte_in[7:2] == mdl_pkg::OPC_AND_RM) begin
						op_next = mdl_pkg::OP_AND_RM;
					end else if (instr_byte_in[7:2] == mdl_pkg::OPC_OR_RM) begin
						op_next = mdl_pkg::OP_OR_RM;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_TEST_RM) begin
						op_next = mdl_pkg::OP_TEST_RM;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_GRP80) begin
						op_next = mdl_pkg::OP_GRP80;
						imm_next = instr_byte_in[0] ? 3'h2 : 3'h1;
					end else if (instr_byte_in[7:1] == mdl_pkg::OPC_AND_ACC
						|| instr_byte_in[7:1] == mdl_pkg::OPC_OR_ACC
						|| instr_byte_in[7:1] == mdl_pkg::OPC_TEST_ACC) begin
						if (instr_byte_in[7:1] == mdl_pkg::OPC_AND_ACC) begin
							op_next = mdl_pkg::OP_AND_ACC;
						end else if (instr_byte_in[7:1] == mdl_pkg::OPC_OR_ACC) begin
							op_next = mdl_pkg::OP_OR_ACC;
						end else begin
							op_next = mdl_pkg::OP_TEST_ACC;
						end
						tail_next = instr_byte_in[0] ? 3'h2 : 3'h1;
						state_next = S_TAIL;
					end else begin
						op_next = mdl_pkg::OP_NONE;
						illegal_next = 1'b1;
						state_next = S_OPC;
					end
				end
			end
			S_SECOND: begin
				if (take) begin
					if (instr_byte_in == mdl_pkg::OPC_ADJ_BASE) begin
						state_next = S_LOAD;
					end else begin
						illegal_next = 1'b1;
						state_next = S_OPC;
					end
				end
			end
			S_MODRM: begin
				if (take) begin
					field_next = instr_byte_in[5:3];
					mem_next = instr_byte_in[7:6] != mdl_pkg::MOD_REG;
					tail_next = disp_bytes(instr_byte_in) + imm_reg;
					state_next = S_LOAD;
					if (op_reg == mdl_pkg::OP_GRP3) begin
						case (instr_byte_in[5:3])
							mdl_pkg::FLD_SMUL: op_next = mdl_pkg::OP_SMUL;
							mdl_pkg::FLD_UDIV: op_next = mdl_pkg::OP_UDIV;
							mdl_pkg::FLD_SDIV: op_next = mdl_pkg::OP_SDIV;
							mdl_pkg::FLD_TEST: begin
								op_next = mdl_pkg::OP_TEST_IMM;
								tail_next = disp_bytes(instr_byte_in) + (word_reg ? 3'h2 : 3'h1);
							end
							default: op_next = mdl_pkg::OP_NONE;
						endcase
					end else if (op_reg == mdl_pkg::OP_GRP80) begin
						case (instr_byte_in[5:3])
							mdl_pkg::FLD_AND: op_next = mdl_pkg::OP_AND_IMM;
							mdl_pkg::FLD_OR: op_next = mdl_pkg::OP_OR_IMM;
							default: op_next = mdl_pkg::OP_NONE;
						endcase
					end else if ((op_reg == mdl_pkg::OP_SH1 || op_reg == mdl_pkg::OP_SHCL
						|| op_reg == mdl_pkg::OP_SHIMM) && instr_byte_in[5:3] == mdl_pkg::FLD_SH_BAD) begin
						op_next = mdl_pkg::OP_NONE;
					end
					if (op_next == mdl_pkg::OP_NONE) begin
						illegal_next = 1'b1;
						state_next = S_OPC;
					end else if (tail_next != 3'h0) begin
						state_next = S_TAIL;
					end
				end
			end
			S_TAIL: begin
				if (take) begin
					last_byte_next = instr_byte_in;
					tail_next = tail_reg - 3'h1;
					if (tail_reg == 3'h1) begin
						state_next = S_LOAD;
					end
				end
			end
			S_LOAD: begin
				cnt_next = tif.clocks;
				clocks_next = tif.clocks;
				state_next = S_EXEC;
			end
			S_EXEC: begin
				if (cnt_reg <= mdl_pkg::ONE_CLOCK) begin
					done_next = 1'b1;
					state_next = S_OPC;
				end else begin
					cnt_next = cnt_reg - mdl_pkg::ONE_CLOCK;
				end
			end
			default: state_next = S_OPC;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// All outputs are registered so the core sees clean levels.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= S_OPC;
			op_reg <= mdl_pkg::OP_NONE;
			field_reg <= 3'h0;
			word_reg <= 1'b0;
			mem_reg <= 1'b0;
			imm_reg <= 3'h0;
			tail_reg <= 3'h0;
			last_byte_reg <= 8'h00;
			cnt_reg <= 9'h000;
			clocks_reg <= 9'h000;
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
			byte_ready_out <= 1'b0;
			busy_out <= 1'b0;
			writes_result_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			field_reg <= field_next;
			word_reg <= word_next;
			mem_reg <= mem_next;
			imm_reg <= imm_next;
			tail_reg <= tail_next;
			last_byte_reg <= last_byte_next;
			cnt_reg <= cnt_next;
			clocks_reg <= clocks_next;
			done_reg <= done_next;
			illegal_reg <= illegal_next;
			byte_ready_out <= state_next == S_OPC || state_next == S_MODRM
				|| state_next == S_SECOND || state_next == S_TAIL;
			busy_out <= state_next == S_EXEC;
			writes_result_out <= !(op_next == mdl_pkg::OP_TEST_RM
				|| op_next == mdl_pkg::OP_TEST_IMM
				|| op_next == mdl_pkg::OP_TEST_ACC || op_next == mdl_pkg::OP_NONE);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign op_class_out = op_reg;
	assign shift_operation_field_out = field_reg;
	assign word_out = word_reg;
	assign mem_out = mem_reg;
	assign clocks_out = clocks_reg;
	assign done_out = done_reg;
	assign illegal_out = illegal_reg;

endmodule

// file: mdl_pkg.sv
// Shared opcodes, field codes and execution clock figures for the decoder.
package mdl_pkg;

	// ----------------------------------------------------------------
	// Instruction classes
	// ----------------------------------------------------------------
	typedef enum {
		OP_NONE, OP_GRP3, OP_GRP80, OP_SMUL, OP_SMUL_IMM, OP_UDIV, OP_SDIV,
		OP_AAM, OP_AAD, OP_CBW, OP_CWD, OP_SH1, OP_SHCL, OP_SHIMM,
		OP_AND_RM, OP_AND_IMM, OP_AND_ACC, OP_OR_RM, OP_OR_IMM, OP_OR_ACC,
		OP_TEST_RM, OP_TEST_IMM, OP_TEST_ACC
	} mdl_op_t;

	// ----------------------------------------------------------------
	// Opcode patterns (upper bits compared, low bits are d/w/s; full 8-bit patterns compared whole)
	// ----------------------------------------------------------------
	localparam logic [6:0] OPC_GRP3 = 7'h7B;      // 1111011w
	localparam logic [5:0] OPC_SMUL_IMM = 6'h1A;  // 011010s1, bit0 must be 1
	localparam logic [7:0] OPC_AAM = 8'hD4;
	localparam logic [7:0] OPC_AAD = 8'hD5;
	localparam logic [7:0] OPC_ADJ_BASE = 8'h0A;
	localparam logic [7:0] OPC_CBW = 8'h98;
	localparam logic [7:0] OPC_CWD = 8'h99;
	localparam logic [6:0] OPC_SH1 = 7'h68;       // 1101000w
	localparam logic [6:0] OPC_SHCL = 7'h69;      // 1101001w
	localparam logic [6:0] OPC_SHIMM = 7'h60;     // 1100000w
	localparam logic [5:0] OPC_AND_RM = 6'h08;    // 001000dw
	localparam logic [5:0] OPC_OR_RM = 6'h02;     // 000010dw
	localparam logic [6:0] OPC_TEST_RM = 7'h42;   // 1000010w
	localparam logic [6:0] OPC_GRP80 = 7'h40;     // 1000000w
	localparam logic [6:0] OPC_AND_ACC = 7'h12;   // 0010010w
	localparam logic [6:0] OPC_OR_ACC = 7'h06;    // 0000110w
	localparam logic [6:0] OPC_TEST_ACC = 7'h54;  // 1010100w

	// ----------------------------------------------------------------
	// Middle field codes and addressing mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] FLD_TEST = 3'h0;
	localparam logic [2:0] FLD_OR = 3'h1;
	localparam logic [2:0] FLD_AND = 3'h4;
	localparam logic [2:0] FLD_SMUL = 3'h5;
	localparam logic [2:0] FLD_UDIV = 3'h6;
	localparam logic [2:0] FLD_SDIV = 3'h7;
	localparam logic [2:0] FLD_SH_BAD = 3'h6;     // Unassigned shift operation.
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_NODISP = 2'h0;
	localparam logic [2:0] RM_DIRECT = 3'h6;

	// Shift operation field values.
	localparam logic [2:0] rotate_left = 3'h0;
	localparam logic [2:0] rotate_right = 3'h1;
	localparam logic [2:0] rotate_carry_left = 3'h2;
	localparam logic [2:0] rotate_carry_right = 3'h3;
	localparam logic [2:0] logical_left_shift = 3'h4;
	localparam logic [2:0] logical_right_shift = 3'h5;
	localparam logic [2:0] arithmetic_right_shift = 3'h7;

	// ----------------------------------------------------------------
	// Clock figures: reg byte, reg word, mem byte, mem word, range span
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rb;
		logic [7:0] rw;
		logic [7:0] mb;
		logic [7:0] mw;
		logic [7:0] span;
		logic star;     // Word memory transfers cost extra on the narrow bus.
		logic per_n;    // Adds one clock per shift position.
	} mdl_time_t;

	localparam mdl_time_t T_SMUL = '{8'h19, 8'h22, 8'h1F, 8'h28, 8'h03, 1'b1, 1'b0};
	localparam mdl_time_t T_SMUL_IMM = '{8'h16, 8'h16, 8'h1D, 8'h1D, 8'h03, 1'b0, 1'b0};
	localparam mdl_time_t T_UDIV = '{8'h1D, 8'h26, 8'h23, 8'h2C, 8'h00, 1'b1, 1'b0};
	localparam mdl_time_t T_SDIV = '{8'h2C, 8'h35, 8'h32, 8'h3B, 8'h08, 1'b1, 1'b0};
	localparam mdl_time_t T_AAM = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h00, 1'b0, 1'b0};
	localparam mdl_time_t T_AAD = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h00, 1'b0, 1'b0};
	localparam mdl_time_t T_CBW = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 1'b0, 1'b0};
	localparam mdl_time_t T_CWD = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 1'b0, 1'b0};
	localparam mdl_time_t T_SH1 = '{8'h02, 8'h02, 8'h0F, 8'h0F, 8'h00, 1'b0, 1'b0};
	localparam mdl_time_t T_SHN = '{8'h05, 8'h05, 8'h11, 8'h11, 8'h00, 1'b0, 1'b1};
	localparam mdl_time_t T_RM = '{8'h03, 8'h03, 8'h0A, 8'h0A, 8'h00, 1'b1, 1'b0};
	localparam mdl_time_t T_IMM = '{8'h04, 8'h04, 8'h10, 8'h10, 8'h00, 1'b1, 1'b0};
	localparam mdl_time_t T_TEST_IMM = '{8'h04, 8'h04, 8'h0A, 8'h0A, 8'h00, 1'b1, 1'b0};
	localparam mdl_time_t T_ACC = '{8'h03, 8'h04, 8'h03, 8'h04, 8'h00, 1'b0, 1'b0};
	localparam logic [8:0] NARROW_WORD_EXTRA = 9'h004;
	localparam logic [8:0] ONE_CLOCK = 9'h001;

endpackage

// file: mdl_time_if.sv
// Interface carrying a timing request from the decoder to the clock table.
`timescale 1ns/1ps
interface mdl_time_if;
	mdl_pkg::mdl_op_t op;
	logic word;
	logic mem;
	logic bus8;
	logic [7:0] var_n;
	logic [8:0] clocks;

	modport decoder (output op, output word, output mem, output bus8, output var_n,
		input clocks);
	modport table_end (input op, input word, input mem, input bus8, input var_n,
		output clocks);
endinterface

// file: mdl_clock_table.sv
// Execution clock lookup for each decoded instruction class.
`timescale 1ns/1ps
module mdl_clock_table (
	mdl_time_if.table_end t
);

	// ----------------------------------------------------------------
	// Figure selection
	// ----------------------------------------------------------------

	// Picks the figure row for a class; unknown classes take the T_CBW row and cost two clocks.
	function automatic mdl_pkg::mdl_time_t row_of(input mdl_pkg::mdl_op_t op);
		case (op)
			mdl_pkg::OP_SMUL: row_of = mdl_pkg::T_SMUL;
			mdl_pkg::OP_SMUL_IMM: row_of = mdl_pkg::T_SMUL_IMM;
			mdl_pkg::OP_UDIV: row_of = mdl_pkg::T_UDIV;
			mdl_pkg::OP_SDIV: row_of = mdl_pkg::T_SDIV;
			mdl_pkg::OP_AAM: row_of = mdl_pkg::T_AAM;
			mdl_pkg::OP_AAD: row_of = mdl_pkg::T_AAD;
			mdl_pkg::OP_CBW: row_of = mdl_pkg::T_CBW;
			mdl_pkg::OP_CWD: row_of = mdl_pkg::T_CWD;
			mdl_pkg::OP_SH1: row_of = mdl_pkg::T_SH1;
			mdl_pkg::OP_SHCL, mdl_pkg::OP_SHIMM: row_of = mdl_pkg::T_SHN;
			mdl_pkg::OP_AND_RM, mdl_pkg::OP_OR_RM, mdl_pkg::OP_TEST_RM: row_of = mdl_pkg::T_RM;
			mdl_pkg::OP_AND_IMM, mdl_pkg::OP_OR_IMM: row_of = mdl_pkg::T_IMM;
			mdl_pkg::OP_TEST_IMM: row_of = mdl_pkg::T_TEST_IMM;
			mdl_pkg::OP_AND_ACC, mdl_pkg::OP_OR_ACC, mdl_pkg::OP_TEST_ACC: row_of = mdl_pkg::T_ACC;
			default: row_of = mdl_pkg::T_CBW;
		endcase
	endfunction

	// Base figure by operand kind, then the data-dependent part, then the
	// narrow-bus surcharge. Outside per_n rows the variable part is clamped to the
	// documented range so a wild operand hint can never stretch a fixed-range op.
	always_comb begin
		mdl_pkg::mdl_time_t r;
		logic [7:0] base;
		logic [7:0] extra;
		base = 8'h00;
		extra = 8'h00;
		r = row_of(t.op);
		case ({t.mem, t.word})
			2'b00: base = r.rb;
			2'b01: base = r.rw;
			2'b10: base = r.mb;
			default: base = r.mw;
		endcase
		if (r.per_n) begin
			extra = t.var_n;
		end else if (t.var_n > r.span) begin
			extra = r.span;
		end else begin
			extra = t.var_n;
		end
		t.clocks = {1'b0, base} + {1'b0, extra};
		if (t.bus8 && r.star && t.word && t.mem) begin
			t.clocks = t.clocks + mdl_pkg::NARROW_WORD_EXTRA;
		end
	end

endmodule

// file: mdl_decoder_checker.sv
// Concurrent checks on the decoder's ports, bound to every decoder instance.
`timescale 1ns/1ps
module mdl_decoder_checker (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Watched ports
	input wire logic byte_ready_out,
	input wire logic bus8_in,
	input var mdl_pkg::mdl_op_t op_class_out,
	input wire logic word_out,
	input wire logic mem_out,
	input wire logic writes_result_out,
	input wire logic [8:0] clocks_out,
	input wire logic busy_out,
	input wire logic done_out
);
	logic [8:0] busy_cnt_reg;
	logic [8:0] busy_cnt_next;

	// ----------------------------------------------------------------
	// Busy cycle counter
	// ----------------------------------------------------------------
	// Counts busy cycles; too long a count would hide a figure off by one.
	always_comb begin
		busy_cnt_next = busy_out ? busy_cnt_reg + 9'h001 : 9'h000;
	end

	// Register the count.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			busy_cnt_reg <= 9'h000;
		end else begin
			busy_cnt_reg <= busy_cnt_next;
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_done_after_busy: assert property ($fell(busy_out) |-> done_out)
		else $error("done did not follow the end of busy");
	chk_busy_length: assert property (done_out |-> busy_cnt_reg == clocks_out)
		else $error("busy length differs from the clock figure");
	chk_ready_while_busy: assert property (busy_out |-> !byte_ready_out)
		else $error("byte accepted during execution");
	chk_writes_flag: assert property (writes_result_out == !(op_class_out inside
		{mdl_pkg::OP_NONE, mdl_pkg::OP_TEST_RM, mdl_pkg::OP_TEST_IMM, mdl_pkg::OP_TEST_ACC}))
		else $error("result write flag wrong for class");
	chk_adjust_clocks: assert property ($rose(busy_out) && op_class_out == mdl_pkg::OP_AAM
		|-> clocks_out == 9'h013 ##18 busy_out ##1 !busy_out && done_out)
		else $error("adjust after multiply figure wrong");
	chk_divide_adjust: assert property ($rose(busy_out) && op_class_out == mdl_pkg::OP_AAD
		|-> clocks_out == 9'h00f)
		else $error("adjust before divide figure wrong");
	chk_extend_clocks: assert property ($rose(busy_out) && op_class_out == mdl_pkg::OP_CBW
		|-> busy_out ##1 busy_out ##1 !busy_out && done_out)
		else $error("byte extend did not take two clocks");
	chk_udiv_clocks: assert property ($rose(busy_out) && op_class_out == mdl_pkg::OP_UDIV
		|-> clocks_out == (mem_out ? (word_out ? (bus8_in ? 9'h030 : 9'h02c) : 9'h023)
		: (word_out ? 9'h026 : 9'h01d)))
		else $error("unsigned divide figure wrong");
	chk_acc_clocks: assert property ($rose(busy_out) && op_class_out inside
		{mdl_pkg::OP_AND_ACC, mdl_pkg::OP_OR_ACC, mdl_pkg::OP_TEST_ACC}
		|-> clocks_out == (word_out ? 9'h004 : 9'h003))
		else $error("accumulator form figure wrong");
endmodule

bind mdl_decoder mdl_decoder_checker u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
	.byte_ready_out(byte_ready_out), .bus8_in(bus8_in), .op_class_out(op_class_out),
	.word_out(word_out), .mem_out(mem_out), .writes_result_out(writes_result_out),
	.clocks_out(clocks_out), .busy_out(busy_out), .done_out(done_out));

// file: test_muldiv_logic_op_decoder.sv
// Self-checking bench for the multiply, divide, shift and logic decoder.
`timescale 1ns/1ps
`define CHECK_EQ(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_muldiv_logic_op_decoder;
	logic mclk_in, reset_in, byte_valid_in, bus8_in, byte_ready_out, word_out, mem_out;
	logic writes_result_out, busy_out, done_out, illegal_out;
	logic [7:0] instr_byte_in, var_count_in;
	logic [2:0] shift_operation_field_out, f;
	logic [8:0] clocks_out;
	mdl_pkg::mdl_op_t op_class_out;
	int n_fail, comparisons, k, j;
	integer seed;
	logic [7:0] bytes_q[$];
	mdl_pkg::mdl_op_t op_tab [20] = '{mdl_pkg::OP_SMUL, mdl_pkg::OP_SMUL_IMM, mdl_pkg::OP_UDIV,
		mdl_pkg::OP_SDIV, mdl_pkg::OP_AAM, mdl_pkg::OP_AAD, mdl_pkg::OP_CBW, mdl_pkg::OP_CWD,
		mdl_pkg::OP_SH1, mdl_pkg::OP_SHCL, mdl_pkg::OP_SHIMM, mdl_pkg::OP_AND_RM,
		mdl_pkg::OP_OR_RM, mdl_pkg::OP_TEST_RM, mdl_pkg::OP_TEST_IMM, mdl_pkg::OP_AND_IMM,
		mdl_pkg::OP_OR_IMM, mdl_pkg::OP_AND_ACC, mdl_pkg::OP_OR_ACC, mdl_pkg::OP_TEST_ACC};
	logic [7:0] opc_tab [20] = '{8'hf6, 8'h69, 8'hf6, 8'hf6, 8'hd4, 8'hd5, 8'h98, 8'h99,
		8'hd0, 8'hd2, 8'hc0, 8'h20, 8'h08, 8'h84, 8'hf6, 8'h80, 8'h80, 8'h24, 8'h0c, 8'ha8};

	mdl_decoder dut (.mclk_in(mclk_in), .reset_in(reset_in), .instr_byte_in(instr_byte_in),
		.byte_valid_in(byte_valid_in), .byte_ready_out(byte_ready_out), .bus8_in(bus8_in),
		.var_count_in(var_count_in), .op_class_out(op_class_out),
		.shift_operation_field_out(shift_operation_field_out), .word_out(word_out),
		.mem_out(mem_out), .writes_result_out(writes_result_out), .clocks_out(clocks_out),
		.busy_out(busy_out), .done_out(done_out), .illegal_out(illegal_out));

	// Core clock, 5 ns period.
	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	// Prints the verdict and ends the run.
	task report_and_stop;
		if (n_fail == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Execution figure for a class; ranged forms add the clamped data part.
	function automatic logic [8:0] exp_clk(int c, logic w, logic m, logic b8, logic [7:0] v,
		logic [7:0] n);
		logic [8:0] r;
		logic [8:0] v3;
		logic [8:0] v8;
		v3 = (v > 8'h03) ? 9'h003 : {1'b0, v};
		v8 = (v > 8'h08) ? 9'h008 : {1'b0, v};
		case (c)
			0: r = (m ? (w ? 9'h028 : 9'h01f) : (w ? 9'h022 : 9'h019)) + v3;
			1: r = (m ? 9'h01d : 9'h016) + v3;
			2: r = m ? (w ? 9'h02c : 9'h023) : (w ? 9'h026 : 9'h01d);
			3: r = (m ? (w ? 9'h03b : 9'h032) : (w ? 9'h035 : 9'h02c)) + v8;
			4: r = 9'h013;
			5: r = 9'h00f;
			6: r = 9'h002;
			7: r = 9'h004;
			8: r = m ? 9'h00f : 9'h002;
			9: r = (m ? 9'h011 : 9'h005) + {1'b0, v};
			10: r = (m ? 9'h011 : 9'h005) + {1'b0, n};
			11, 12, 13: r = m ? 9'h00a : 9'h003;
			14: r = m ? 9'h00a : 9'h004;
			15, 16: r = m ? 9'h010 : 9'h004;
			default: r = w ? 9'h004 : 9'h003;
		endcase
		if (b8 && w && m && (c == 0 || c == 2 || c == 3 || (c >= 11 && c <= 16))) r = r + 9'h004;
		return r;
	endfunction

	// Offers each queued byte and holds it until the decoder takes it.
	task automatic send_all;
		int g;
		foreach (bytes_q[i]) begin
			byte_valid_in = 1'b1;
			instr_byte_in = bytes_q[i];
			g = 0;
			while (byte_ready_out !== 1'b1 && g < 400) begin
				@(posedge mclk_in);
				#1 g++;
			end
			if (g >= 400) begin
				n_fail++;
				report_and_stop();
			end
			@(posedge mclk_in);
			#1;
		end
		byte_valid_in = 1'b0;
	endtask

	// Builds one instruction of class c, runs it and checks its result ports, but not illegal_out.
	task automatic issue(int c, logic w, logic [1:0] md, logic [2:0] rm, logic [2:0] fld,
		logic [7:0] v, logic b8);
		logic [7:0] n;
		logic [8:0] ec;
		logic m, we;
		int nt, nd, g, nb;
		n = 8'($random(seed));
		m = md != 2'h3 && !(c == 1 ? 1'b0 : (c >= 4 && c <= 7) || c >= 17);
		we = (c == 1) ? 1'b1 : w;
		nt = (c == 1) ? (w ? 1 : 2) : (c == 10) ? 1 : (c >= 14 && c != 13) ? 1 + w : 0;
		nd = !m ? 0 : (md == 2'h1) ? 1 : (md == 2'h2 || rm == 3'h6) ? 2 : 0;
		fld = (c == 0) ? 3'h5 : (c == 2) ? 3'h6 : (c == 3) ? 3'h7 : (c == 14) ? 3'h0
			: (c == 15) ? 3'h4 : (c == 16) ? 3'h1 : fld;
		// Adjust and extend opcodes carry no width bit; the multiply's s bit follows w.
		bytes_q = '{opc_tab[c] | ((c == 1) ? {6'h00, w, 1'b0}
			: (c >= 4 && c <= 7) ? 8'h00 : {7'h00, w})};
		if (c >= 4 && c <= 5) bytes_q.push_back(8'h0a);
		if ((c < 4 || c > 7) && c < 17) bytes_q.push_back({md, fld, rm});
		repeat (nd + nt) bytes_q.push_back(8'($random(seed)));
		if (c == 10) bytes_q[bytes_q.size() - 1] = n;
		bus8_in = b8;
		var_count_in = v;
		ec = exp_clk(c, we, m, b8, v, n);
		send_all();
		g = 0;
		nb = 0;
		while (done_out !== 1'b1 && g < 600) begin
			@(posedge mclk_in);
			#1 g++;
			if (busy_out === 1'b1) nb++;
		end
		`CHECK_EQ("done", 1'b1, done_out)
		`CHECK_EQ("clocks", ec, clocks_out)
		`CHECK_EQ("busy length", ec, 9'(nb))
		`CHECK_EQ("class", op_tab[c], op_class_out)
		`CHECK_EQ("writes", !(c == 13 || c == 14 || c == 19), writes_result_out)
		if (c < 4 || (c > 7 && c < 17)) `CHECK_EQ("memory", m, mem_out)
		if (c < 4 || c > 7) `CHECK_EQ("word", we, word_out)
		if (c >= 8 && c <= 10) `CHECK_EQ("shift field", fld, shift_operation_field_out)
	endtask

	// Sends a two-byte sequence that must be refused as illegal.
	task automatic check_illegal(logic [7:0] a, logic [7:0] b, mdl_pkg::mdl_op_t ex);
		logic seen;
		seen = 1'b0;
		bytes_q = '{a, b};
		send_all();
		repeat (4) begin
			if (illegal_out === 1'b1) seen = 1'b1;
			@(posedge mclk_in);
			#1;
		end
		`CHECK_EQ("illegal", 1'b1, seen)
		`CHECK_EQ("class after illegal", ex, op_class_out)
	endtask

	// Watchdog sized well beyond the longest expected run.
	initial begin
		#500000;
		n_fail++;
		report_and_stop();
	end

	// Main sequence: sweep, shift fields, random stream, refusals, reset in mid-run.
	initial begin
		seed = 32'h89c0;
		n_fail = 0;
		comparisons = 0;
		reset_in = 1'b1;
		byte_valid_in = 1'b0;
		instr_byte_in = 8'h00;
		bus8_in = 1'b0;
		var_count_in = 8'h00;
		repeat (3) @(posedge mclk_in);
		#1 reset_in = 1'b0;
		for (k = 0; k < 20; k++) begin
			for (j = 0; j < 8; j++) issue(k, j[0], j[1] ? 2'h2 : 2'h3, 3'h1, 3'h1, 8'hff, j[2]);
		end
		for (j = 0; j < 8; j++) begin
			if (j != 6) issue(8, 1'b1, 2'h0, 3'h6, 3'(j), 8'h00, 1'b1);
		end
		repeat (200) begin
			k = {$random(seed)} % 20;
			f = 3'($random(seed));
			if (f == 3'h6) f = 3'h7;
			issue(k, 1'($random(seed)), 2'($random(seed)), 3'($random(seed)), f,
				8'($random(seed)), 1'($random(seed)));
		end
		// A refused adjust base byte leaves the adjust class showing.
		check_illegal(8'hd0, 8'hf0, mdl_pkg::OP_NONE);
		check_illegal(8'hd4, 8'h05, mdl_pkg::OP_AAM);
		check_illegal(8'hf6, 8'he0, mdl_pkg::OP_NONE);
		bytes_q = '{8'hf7, 8'hf8};
		send_all();
		repeat (5) @(posedge mclk_in);
		#1 reset_in = 1'b1;
		@(posedge mclk_in);
		#1 `CHECK_EQ("busy in reset", 1'b0, busy_out)
		reset_in = 1'b0;
		issue(6, 1'b0, 2'h3, 3'h0, 3'h0, 8'h00, 1'b0);
		report_and_stop();
	end
endmodule
